// ===== design/lmsc_defs.vh
// Constants for the serial configuration port and LO-mode register file
`ifndef LMSC_DEFS_VH
`define LMSC_DEFS_VH
// ****************************************************************
// Frame layout
// ****************************************************************
`define LMSC_FRAME_BITS     24
`define LMSC_CNT_W          5
`define LMSC_RW_BIT         23
`define LMSC_ADDR_HI        22
`define LMSC_ADDR_LO        16
`define LMSC_DATA_HI        15
`define LMSC_DATA_LO        0
`define LMSC_RW_WRITE       1'b0
`define LMSC_RW_READ        1'b1
// ****************************************************************
// Register addresses
// ****************************************************************
`define LMSC_PLL_CONTROL    7'h00
`define LMSC_STARTUP_SETUP  7'h06
`define LMSC_LO_OUTPUT_CTL  7'h2c
`define LMSC_SIG_PATH_CTL   7'h4f
`define LMSC_LO_SOURCE_SEL  7'h50
`define LMSC_LO_DRV_CLK_CFG 7'h51
`define LMSC_QUAD_FILT_CFG  7'h67
`define LMSC_EXT_LO_TERM    7'h7b
`define LMSC_STARTUP_ACCESS 7'h7f
// ****************************************************************
// Field positions
// ****************************************************************
`define LMSC_SOFT_RESET_BIT 1
`define LMSC_SYNTH_PD_BIT   0
`define LMSC_VCO_CAL_BIT    3
`define LMSC_LO_OUTPUT_POWER_DOWN_BIT  7
`define LMSC_SIGCHAIN_BIT   0
`define LMSC_PATH_EN_HI     14
`define LMSC_PATH_EN_LO     12
`define LMSC_SRC_SEL_HI     5
`define LMSC_SRC_SEL_LO     0
`define LMSC_SM_CLK_BIT     0
`define LMSC_CLK_DRV_HI     2
`define LMSC_CLK_DRV_LO     1
`define LMSC_DRV_MODE_HI    5
`define LMSC_DRV_MODE_LO    4
`define LMSC_CLK_DIV_HI     7
`define LMSC_CLK_DIV_LO     6
`define LMSC_QF_A_HI        11
`define LMSC_QF_A_LO        8
`define LMSC_QF_B_HI        13
`define LMSC_QF_B_LO        10
`define LMSC_TERM_HI        1
`define LMSC_TERM_LO        0
// ****************************************************************
// Decoded LO modes and source codes
// ****************************************************************
`define LMSC_MODE_HALVING   2'h0
`define LMSC_MODE_QUAD      2'h1
`define LMSC_MODE_EXTERNAL  2'h2
`define LMSC_MODE_UNKNOWN   2'h3
`define LMSC_SRC_HALVING    6'h09
`define LMSC_SRC_QUAD       6'h0a
`define LMSC_SRC_EXTERNAL   6'h22
`define LMSC_ZERO16         16'h0000
`endif

// ===== design/lmsc_reg_file.v
// Register array of the serial configuration port
`timescale 1ns/1ps
module lmsc_reg_file #(
   parameter DEPTH  = 128,
   parameter AW     = 7,
   parameter DW     = 16,
   parameter [DEPTH*DW-1:0] POR_IMAGE = {DEPTH*DW{1'b0}}
) (
   // Clock and reset
   input  wire          i_ref_clk,
   input  wire          i_resetn,
   input  wire          i_ce,
   // Write and soft reset
   input  wire          i_wr_en,
   input  wire [AW-1:0] i_wr_addr,
   input  wire [DW-1:0] i_wr_data,
   input  wire          i_restore,
   // Read port
   input  wire [AW-1:0] i_rd_addr,
   output wire [DW-1:0] o_rd_data,
   output wire [DEPTH*DW-1:0] o_all
);
`include "lmsc_defs.vh"
   // ****************************************************************
   // One register per entry
   // ****************************************************************
   genvar g;
   generate
      for (g = 0; g < DEPTH; g = g + 1) begin : gen_reg
         reg [DW-1:0] word_reg;
         // Power-on and soft reset both load the power-on image
         always @(posedge i_ref_clk or negedge i_resetn) begin
            if (!i_resetn) begin
               word_reg <= POR_IMAGE[g*DW +: DW];
            end else if (i_ce) begin
               if (i_restore) begin
                  word_reg <= POR_IMAGE[g*DW +: DW];
               end else if (i_wr_en && (i_wr_addr == g)) begin
                  word_reg <= i_wr_data;
               end
            end
         end
         assign o_all[g*DW +: DW] = word_reg;
      end
   endgenerate

   // Read mux picks the addressed word
   assign o_rd_data = o_all[i_rd_addr*DW +: DW];
endmodule

// ===== design/lmsc_serial_port.v
// Serial configuration port with LO-mode control decode
`timescale 1ns/1ps
module lmsc_serial_port #(
   parameter DEPTH = 128,
   parameter AW    = 7,
   parameter DW    = 16,
   parameter [DEPTH*DW-1:0] POR_IMAGE = {DEPTH*DW{1'b0}}
) (
   // Clock, reset, enable
   input  wire          i_ref_clk,
   input  wire          i_resetn,
   input  wire          i_ce,
   // Serial port from the host
   input  wire          i_sclk,
   input  wire          i_chip_select_n,
   input  wire          i_sdi,
   // Serial readback
   output reg           o_sdo,
   output reg           o_sdo_oe,
   // Decoded LO-mode controls
   output reg  [1:0]    o_lo_mode,
   output reg           o_synth_power_down,
   output reg           o_lo_output_power_down,
   output reg           o_signal_chain_power_down,
   output reg  [2:0]    o_lo_path_enable,
   output reg  [5:0]    o_lo_source_select,
   output reg           o_state_machine_clock_select,
   output reg  [1:0]    o_external_clock_driver_enable,
   output reg  [1:0]    o_lo_driver_mode,
   output reg  [1:0]    o_external_clock_divider_enable,
   output reg  [3:0]    o_quadrature_filter_setting_a,
   output reg  [3:0]    o_quadrature_filter_setting_b,
   output reg  [1:0]    o_external_input_termination,
   output reg           o_vco_calibration_enable,
   output reg           o_use_quad_filter_path,
   output reg           o_sm_clock_from_lo
);
`include "lmsc_defs.vh"
   // ****************************************************************
   // Serial front end
   // ****************************************************************
   reg                    sclk_d_reg;
   reg                    csn_d_reg;
   reg [`LMSC_FRAME_BITS-1:0] shift_reg;
   reg [`LMSC_CNT_W-1:0]  count_reg;
   reg                    over_reg;
   reg [DW-1:0]           rd_shift_reg;
   wire                   sclk_rise;
   wire                   sclk_fall;
   wire                   cs_rise;
   wire                   active;
   wire                   frame_full;
   wire                   wr_en;
   wire                   restore;
   wire [AW-1:0]          rd_addr;
   wire [DW-1:0]          rd_data;
   wire [DEPTH*DW-1:0]    all_regs;
   wire [DW-1:0]          r_pll;
   wire [DW-1:0]          r_lout;
   wire [DW-1:0]          r_path;
   wire [DW-1:0]          r_src;
   wire [DW-1:0]          r_drv;
   wire [DW-1:0]          r_qf;
   wire [DW-1:0]          r_term;

   assign sclk_rise  = i_sclk & ~sclk_d_reg;
   assign sclk_fall  = ~i_sclk & sclk_d_reg;
   assign cs_rise    = i_chip_select_n & ~csn_d_reg;
   assign active     = ~i_chip_select_n;
   assign frame_full = (count_reg == `LMSC_FRAME_BITS) && !over_reg;
   // Write only for a complete write frame, at deselect
   assign wr_en = cs_rise && frame_full &&
                  (shift_reg[`LMSC_RW_BIT] == `LMSC_RW_WRITE);
   // Soft reset bit in the PLL word is held as a restore request
   assign restore = r_pll[`LMSC_SOFT_RESET_BIT];
   // Read address comes from the address field once shifted in
   assign rd_addr = shift_reg[AW-1:0];

   // Edge history of the host pins
   always @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         sclk_d_reg <= 1'b0;
         csn_d_reg  <= 1'b1;
      end else if (i_ce) begin
         sclk_d_reg <= i_sclk;
         csn_d_reg  <= i_chip_select_n;
      end
   end

   // Shift in MSB first on clock rise; overlong frames are dropped
   always @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         shift_reg <= {`LMSC_FRAME_BITS{1'b0}};
         count_reg <= {`LMSC_CNT_W{1'b0}};
         over_reg  <= 1'b0;
      end else if (i_ce) begin
         if (!active) begin
            count_reg <= {`LMSC_CNT_W{1'b0}};
            over_reg  <= 1'b0;
         end else if (sclk_rise) begin
            shift_reg <= {shift_reg[`LMSC_FRAME_BITS-2:0], i_sdi};
            if (count_reg == `LMSC_FRAME_BITS) begin
               over_reg <= 1'b1;
            end else begin
               count_reg <= count_reg + 1'b1;
            end
         end
      end
   end

   // Read answer: load after the address byte, shift out on clock fall
   always @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rd_shift_reg <= `LMSC_ZERO16;
         o_sdo        <= 1'b0;
         o_sdo_oe     <= 1'b0;
      end else if (i_ce) begin
         if (!active) begin
            o_sdo_oe <= 1'b0;
         end else if (sclk_fall && count_reg == (`LMSC_FRAME_BITS - DW) &&
                      shift_reg[AW] == `LMSC_RW_READ) begin
            rd_shift_reg <= {rd_data[DW-2:0], 1'b0};
            o_sdo        <= rd_data[DW-1];
            o_sdo_oe     <= 1'b1;
         end else if (sclk_fall && o_sdo_oe) begin
            o_sdo        <= rd_shift_reg[DW-1];
            rd_shift_reg <= {rd_shift_reg[DW-2:0], 1'b0};
         end
      end
   end

   // ****************************************************************
   // Register file
   // ****************************************************************
   lmsc_reg_file #(
      .DEPTH     (DEPTH),
      .AW        (AW),
      .DW        (DW),
      .POR_IMAGE (POR_IMAGE)
   ) u_regs (
      .i_ref_clk (i_ref_clk),
      .i_resetn  (i_resetn),
      .i_ce      (i_ce),
      .i_wr_en   (wr_en),
      .i_wr_addr (shift_reg[`LMSC_ADDR_HI:`LMSC_ADDR_LO]),
      .i_wr_data (shift_reg[`LMSC_DATA_HI:`LMSC_DATA_LO]),
      .i_restore (restore),
      .i_rd_addr (rd_addr),
      .o_rd_data (rd_data),
      .o_all     (all_regs)
   );

   assign r_pll  = all_regs[`LMSC_PLL_CONTROL*DW    +: DW];
   assign r_lout = all_regs[`LMSC_LO_OUTPUT_CTL*DW  +: DW];
   assign r_path = all_regs[`LMSC_SIG_PATH_CTL*DW   +: DW];
   assign r_src  = all_regs[`LMSC_LO_SOURCE_SEL*DW  +: DW];
   assign r_drv  = all_regs[`LMSC_LO_DRV_CLK_CFG*DW +: DW];
   assign r_qf   = all_regs[`LMSC_QUAD_FILT_CFG*DW  +: DW];
   assign r_term = all_regs[`LMSC_EXT_LO_TERM*DW    +: DW];

   // ****************************************************************
   // LO-mode control outputs, registered
   // ****************************************************************
   always @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_lo_mode                       <= `LMSC_MODE_UNKNOWN;
         o_synth_power_down              <= 1'b0;
         o_lo_output_power_down          <= 1'b0;
         o_signal_chain_power_down       <= 1'b0;
         o_lo_path_enable                <= 3'h0;
         o_lo_source_select              <= 6'h00;
         o_state_machine_clock_select    <= 1'b0;
         o_external_clock_driver_enable  <= 2'h0;
         o_lo_driver_mode                <= 2'h0;
         o_external_clock_divider_enable <= 2'h0;
         o_quadrature_filter_setting_a   <= 4'h0;
         o_quadrature_filter_setting_b   <= 4'h0;
         o_external_input_termination    <= 2'h0;
         o_vco_calibration_enable        <= 1'b0;
         o_use_quad_filter_path          <= 1'b0;
         o_sm_clock_from_lo              <= 1'b0;
      end else if (i_ce) begin
         o_synth_power_down <= r_pll[`LMSC_SYNTH_PD_BIT];
         o_lo_output_power_down <= r_lout[`LMSC_LO_OUTPUT_POWER_DOWN_BIT];
         o_signal_chain_power_down <= r_path[`LMSC_SIGCHAIN_BIT];
         o_lo_path_enable <= r_path[`LMSC_PATH_EN_HI:`LMSC_PATH_EN_LO];
         o_lo_source_select <= r_src[`LMSC_SRC_SEL_HI:`LMSC_SRC_SEL_LO];
         o_state_machine_clock_select <= r_drv[`LMSC_SM_CLK_BIT];
         o_external_clock_driver_enable <=
            r_drv[`LMSC_CLK_DRV_HI:`LMSC_CLK_DRV_LO];
         o_lo_driver_mode <= r_drv[`LMSC_DRV_MODE_HI:`LMSC_DRV_MODE_LO];
         o_external_clock_divider_enable <=
            r_drv[`LMSC_CLK_DIV_HI:`LMSC_CLK_DIV_LO];
         o_quadrature_filter_setting_a <= r_drv[`LMSC_QF_A_HI:`LMSC_QF_A_LO];
         o_quadrature_filter_setting_b <= r_qf[`LMSC_QF_B_HI:`LMSC_QF_B_LO];
         o_external_input_termination <= r_term[`LMSC_TERM_HI:`LMSC_TERM_LO];
         o_vco_calibration_enable <= r_pll[`LMSC_VCO_CAL_BIT];
         // Source select code names the mode; other codes read unknown
         case (r_src[`LMSC_SRC_SEL_HI:`LMSC_SRC_SEL_LO])
            `LMSC_SRC_HALVING: begin
               o_lo_mode <= `LMSC_MODE_HALVING;
            end
            `LMSC_SRC_QUAD: begin
               o_lo_mode <= `LMSC_MODE_QUAD;
            end
            `LMSC_SRC_EXTERNAL: begin
               o_lo_mode <= `LMSC_MODE_EXTERNAL;
            end
            default: begin
               o_lo_mode <= `LMSC_MODE_UNKNOWN;
            end
         endcase
         // External LO cannot use halving, so the filter path is forced
         o_use_quad_filter_path <=
            (r_src[`LMSC_SRC_SEL_HI:`LMSC_SRC_SEL_LO] != `LMSC_SRC_HALVING);
         // Clock from divided LO only with select set in external mode
         o_sm_clock_from_lo <= r_drv[`LMSC_SM_CLK_BIT] &&
            (r_src[`LMSC_SRC_SEL_HI:`LMSC_SRC_SEL_LO] == `LMSC_SRC_EXTERNAL);
      end
   end
endmodule

// ===== verif/lmsc_monitor.sv
// Checker of decoded LO controls and readback enable
`timescale 1ns/1ps
module lmsc_monitor (
   // Clock and reset
   input wire       i_ref_clk,
   input wire       i_resetn,
   // Serial port
   input wire       i_chip_select_n,
   input wire       o_sdo_oe,
   // Decoded controls
   input wire [1:0] o_lo_mode,
   input wire [5:0] o_lo_source_select,
   input wire       o_state_machine_clock_select,
   input wire       o_use_quad_filter_path,
   input wire       o_sm_clock_from_lo
);
   // ****
   // Helpers
   // ****
   reg  [1:0] settle_reg;
   wire       settled = settle_reg[1];
   wire [5:0] src     = o_lo_source_select;
   // Outputs show reset values for one edge after release, so wait two
   always @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn)
         settle_reg <= 2'h0;
      else if (!settled)
         settle_reg <= settle_reg + 2'h1;
   end
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_resetn);
   sequence s_idle3; i_chip_select_n [*3]; endsequence
   sequence s_sel3; !i_chip_select_n [*3]; endsequence
   // ****
   // Properties
   // ****
   AST_MODE_HALV: assert property (
      settled && src == 6'h09 |-> o_lo_mode == 2'h0)
      else $error("halving source without halving mode");
   AST_MODE_QUAD: assert property (
      settled && src == 6'h0a |-> o_lo_mode == 2'h1)
      else $error("filter source without filter mode");
   AST_MODE_EXT: assert property (
      settled && src == 6'h22 |-> o_lo_mode == 2'h2)
      else $error("external source without external mode");
   AST_MODE_OTHER: assert property (
      settled && !(src inside {6'h09, 6'h0a, 6'h22}) |-> o_lo_mode == 2'h3)
      else $error("unlisted source with a listed mode");
   AST_QUAD_PATH: assert property (
      settled |-> o_use_quad_filter_path == (src != 6'h09))
      else $error("filter path flag wrong");
   AST_SM_FROM_LO: assert property (
      settled |-> o_sm_clock_from_lo ==
         (o_state_machine_clock_select && src == 6'h22))
      else $error("machine clock source flag wrong");
   AST_HOLD_SELECTED: assert property (
      s_sel3 |-> $stable(src) && $stable(o_state_machine_clock_select))
      else $error("control changed inside a frame");
   AST_OE_IDLE: assert property (
      s_idle3 |-> !o_sdo_oe)
      else $error("readback driven while deselected");
   AST_OE_RELEASE: assert property (
      $rose(i_chip_select_n) |-> ##[1:3] !o_sdo_oe)
      else $error("readback not released after deselect");
endmodule
bind lmsc_serial_port lmsc_monitor mon_u (
   .i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
   .i_chip_select_n(i_chip_select_n), .o_sdo_oe(o_sdo_oe),
   .o_lo_mode(o_lo_mode), .o_lo_source_select(o_lo_source_select),
   .o_state_machine_clock_select(o_state_machine_clock_select),
   .o_use_quad_filter_path(o_use_quad_filter_path),
   .o_sm_clock_from_lo(o_sm_clock_from_lo));

// ===== verif/lmsc_host_model.sv
// Host model that shifts serial frames into the configuration port
`timescale 1ns/1ps
module lmsc_host_model (
   // Clock
   input  wire i_ref_clk,
   // Serial port towards the device
   output reg  o_sclk,
   output reg  o_chip_select_n,
   output reg  o_sdi,
   input  wire i_sdo,
   input  wire i_sdo_oe
);
   initial begin
      o_sclk = 1'b0;
      o_chip_select_n = 1'b1;
      o_sdi = 1'b0;
   end
   // ****
   // Frame driver
   // ****
   // Each clock phase lasts two reference clocks; the port needs one;
   // nbits below 24 truncates. Undriven readback reads as unknown.
   task automatic frame(input logic [23:0] w, input int nbits,
                        output logic [15:0] rd);
      int i;
      rd = 16'h0000;
      @(posedge i_ref_clk);
      o_chip_select_n <= 1'b0;
      for (i = 0; i < nbits; i++) begin
         o_sdi <= w[23 - i];
         repeat (2) @(posedge i_ref_clk);
         o_sclk <= 1'b1;
         repeat (2) @(posedge i_ref_clk);
         rd = {rd[14:0], i_sdo_oe ? i_sdo : 1'bx};
         o_sclk <= 1'b0;
      end
      repeat (2) @(posedge i_ref_clk);
      o_chip_select_n <= 1'b1;
      o_sdi <= ~o_sdi; // Released line does not hold its last bit
      repeat (5) @(posedge i_ref_clk);
   endtask
endmodule

// ===== verif/lo_mode_serial_config_test.sv
// Testbench of the serial configuration port
`timescale 1ns/1ps
module lo_mode_serial_config_test;
   localparam LIMIT = 20000;
   reg         i_ref_clk, i_resetn, i_ce;
   wire        sclk, csn, sdi, sdo, sdo_oe, pd, lpd, spd, smsel, vco;
   wire        quad, smlo;
   wire [1:0]  mode, drv, dmode, div, term;
   wire [2:0]  path;
   wire [3:0]  qfa, qfb;
   wire [5:0]  src;
   wire [28:0] cfg = {pd, lpd, spd, path, src, smsel, drv, dmode, div,
                      qfa, qfb, term};
   int         mismatches = 0, comparisons = 0, cycles = 0, m, i;
   logic [15:0] rd;
   // Mode writes in descending address order, one row per mode
   logic [6:0]  adr [7] = '{7'h7b, 7'h67, 7'h51, 7'h50, 7'h4f, 7'h2c, 7'h00};
   logic [15:0] dat [3][7] = '{
      '{16'h0000, 16'h2c00, 16'h0310, 16'h0009, 16'h0000, 16'h0080, 16'h0000},
      '{16'h0000, 16'h0000, 16'h0000, 16'h000a, 16'h7000, 16'h0080, 16'h0000},
      '{16'h0003, 16'h0000, 16'h0ff7, 16'h0022, 16'h7000, 16'h0080, 16'h0001}};
   logic [28:0] exp_cfg [3] = '{
      {3'h2, 3'h0, 6'h09, 1'h0, 2'h0, 2'h1, 2'h0, 4'h3, 4'hb, 2'h0},
      {3'h2, 3'h7, 6'h0a, 7'h00, 4'h0, 4'h0, 2'h0},
      {3'h6, 3'h7, 6'h22, 1'h1, 2'h3, 2'h3, 2'h3, 4'hf, 4'h0, 2'h3}};
   lmsc_host_model host_u (.i_ref_clk(i_ref_clk), .o_sclk(sclk),
      .o_chip_select_n(csn), .o_sdi(sdi), .i_sdo(sdo), .i_sdo_oe(sdo_oe));
   lmsc_serial_port dut_u (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
      .i_ce(i_ce), .i_sclk(sclk), .i_chip_select_n(csn), .i_sdi(sdi),
      .o_sdo(sdo), .o_sdo_oe(sdo_oe), .o_lo_mode(mode),
      .o_synth_power_down(pd), .o_lo_output_power_down(lpd),
      .o_signal_chain_power_down(spd), .o_lo_path_enable(path),
      .o_lo_source_select(src), .o_state_machine_clock_select(smsel),
      .o_external_clock_driver_enable(drv), .o_lo_driver_mode(dmode),
      .o_external_clock_divider_enable(div),
      .o_quadrature_filter_setting_a(qfa),
      .o_quadrature_filter_setting_b(qfb),
      .o_external_input_termination(term),
      .o_vco_calibration_enable(vco), .o_use_quad_filter_path(quad),
      .o_sm_clock_from_lo(smlo));
   // ****
   // Tasks
   // ****
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      host_u.frame({1'b0, a, d}, 24, rd);
   endtask
   // Read frames carry ones in the data field, which must not be written
   task automatic rd_chk(input logic [6:0] a, input logic [15:0] d);
      host_u.frame({1'b1, a, 16'hffff}, 24, rd);
      chk(rd, d);
   endtask
   task automatic conclude();
      if (mismatches == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // ****
   // Clock, watchdog and sequence
   // ****
   initial begin
      i_ref_clk = 1'b0;
      forever #25 i_ref_clk = ~i_ref_clk;
   end
   // A hung handshake ends the run as a failure
   always @(posedge i_ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         mismatches++;
         conclude();
      end
   end
   initial begin
      i_resetn = 1'b0;
      i_ce = 1'b1;
      repeat (20) @(posedge i_ref_clk);
      i_resetn <= 1'b1;
      repeat (2) @(posedge i_ref_clk);
      chk(mode, 2'h3);
      rd_chk(7'h7f, 16'h0000);
      wr(7'h7f, 16'h0003);
      wr(7'h06, 16'h0100);
      rd_chk(7'h7f, 16'h0003);
      rd_chk(7'h06, 16'h0100);
      wr(7'h7f, 16'h0000);
      wr(7'h01, 16'ha5c3);
      host_u.frame({1'b0, 7'h01, 16'h1111}, 23, rd);
      rd_chk(7'h01, 16'ha5c3);
      for (m = 0; m < 3; m++) begin
         for (i = 0; i < 7; i++) wr(adr[i], dat[m][i]);
         chk(cfg, exp_cfg[m]);
         chk(mode, m[1:0]);
         chk({quad, smlo}, {m != 0, m == 2});
         rd_chk(7'h51, dat[m][2]);
         // Settling wait shortened to keep the run short
         repeat (20) @(posedge i_ref_clk);
         wr(7'h00, dat[m][6] | 16'h0008);
         chk({vco, pd}, {1'b1, dat[m][6][0]});
      end
      wr(7'h00, 16'h0002);
      chk(mode, 2'h3);
      rd_chk(7'h51, 16'h0000);
      rd_chk(7'h01, 16'h0000);
      wr(7'h00, 16'h0000);
      wr(7'h50, 16'h0009);
      chk(mode, 2'h0);
      i_resetn <= 1'b0;
      repeat (3) @(posedge i_ref_clk);
      i_resetn <= 1'b1;
      repeat (2) @(posedge i_ref_clk);
      rd_chk(7'h50, 16'h0000);
      conclude();
   end
endmodule
